// File: src/dcc_dma_channel_control.sv
// Purpose: dma channel 0 engine and channel 1 enable/count control
// Assumes: single 10 MHz clock, memory bus answers with MEM_READY
// Notes:   read bytes wait in a fifo before they are written
`timescale 1ns/10ps

module dcc_fifo #(
    parameter  int WIDTH = 8,
    parameter  int DEPTH = 8,
    localparam int PW    = $clog2(DEPTH),
    localparam int LW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [LW-1:0]         level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wptr;
    logic [PW-1:0]    rptr;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
        $error("fifo depth must be at least 2");
    end

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign in_ready  = level != LW'(DEPTH);
    assign out_valid = level != '0;
    assign out_data  = mem[rptr];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wptr] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr  <= '0;
            rptr  <= '0;
            level <= '0;
        end
        else
        begin
            if (push)
                wptr <= bump(wptr);
            if (pop)
                rptr <= bump(rptr);
            level <= level + LW'(push) - LW'(pop);
        end
    end
endmodule

// Function
// - source address register holds 20 bits, memory or i/o space
// - status register reads back whether each channel is running or done
// - channel 1 runs only while its enable and main enable are set
// - channel 1 enable clears itself when its byte count reaches zero
// - interrupt request held while channel 1 disabled and its interrupt enabled
// - a status write changes channel 1 enable only when its write mask is written zero
// - writing enable zero halts channel 1, keeping state for resume
// - writing enable one also sets main enable
// - reset clears channel 1 enable
// - source mode: increment, decrement, fixed memory, fixed i/o
// - i/o to i/o unsupported; reserved mode pairs never run
// - destination mode: increment, decrement, fixed, fixed i/o; fixed refused with fixed memory or i/o source
// - fixed memory source works with incrementing destination
// - edge-sensed request starts or restarts transfer after recognition
// - transfer-end output low during write of final byte
// - request and transfer-end pins shared with serial clock pins
// - 20-bit addresses carry across 64KB boundaries
// - each channel has a 16-bit byte count
module dcc_dma_channel_control #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // processor i/o register port
    input  wire logic [7:0]  IO_ADDR,
    input  wire logic        IO_WR,
    input  wire logic        IO_RD,
    input  wire logic [7:0]  IO_WDATA,
    output logic [7:0]       IO_RDATA,
    // dma bus master
    output logic [19:0]      MEM_ADDR,
    output logic             MEM_IO,
    output logic             MEM_RD,
    output logic             MEM_WR,
    output logic [7:0]       MEM_WDATA,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic        MEM_READY,
    // shared request and transfer-end pins
    input  wire logic        PIN_REQ_IN,
    output logic             PIN_REQ_OUT,
    output logic             PIN_REQ_OE,
    input  wire logic        PIN_END_IN,
    output logic             PIN_END_OUT,
    output logic             PIN_END_OE,
    // serial channel side
    output logic             SER0_CLK_IN,
    input  wire logic        SER0_CLK_OUT,
    input  wire logic        SER0_CLK_OE,
    output logic             SER1_CLK_IN,
    input  wire logic        SER1_CLK_OUT,
    input  wire logic        SER1_CLK_OE,
    input  wire logic        SER_DMA_REQ,
    // channel 1 data path
    input  wire logic        CH1_ACK,
    output logic             CH1_ACTIVE,
    // interrupt
    output logic             DMA_IRQ
);
    localparam int LW = $clog2(FIFO_DEPTH + 1);

    typedef enum {ST_IDLE, ST_RD, ST_WR} dcc_state_e;

    dcc_state_e                st;
    logic [19:0]               sar;
    logic [19:0]               dar;
    logic [15:0]               ch0_cnt;
    logic [15:0]               ch1_cnt;
    logic [7:0]                mode;
    logic                      ch1_en, ch0_en, ch1_ie, ch0_ie, main_en;
    logic                      tend_n;
    logic                      s1, s2, s3, req_n_q;
    logic                      req_prev, pend;
    logic                      fifo_in_ready, fifo_out_valid;
    logic [7:0]                fifo_data;
    logic [LW-1:0]             fifo_level;
    logic [1:0]                sm, dm;
    logic                      mux, edge_mode, req_active, mode_ok, req_ok;
    logic                      run0, can_read, start_wr, rd_done, wr_done;
    logic                      ch0_term, ch1_term, wr_stat;
    logic [7:0]                rd_mux;

    assign sm         = mode[dcc_pkg::MODE_SM +: 2];
    assign dm         = mode[dcc_pkg::MODE_DM +: 2];
    assign mux        = mode[dcc_pkg::MODE_MUX];
    assign edge_mode  = mode[dcc_pkg::MODE_EDGE];
    assign wr_stat    = IO_WR && IO_ADDR == dcc_pkg::ADDR_STAT;
    assign run0       = ch0_en & main_en;
    assign CH1_ACTIVE = ch1_en & main_en;
    assign DMA_IRQ    = (~ch1_en & ch1_ie) | (~ch0_en & ch0_ie);

    assign SER0_CLK_IN = mux ? 1'b0 : PIN_REQ_IN;
    assign SER1_CLK_IN = mux ? 1'b0 : PIN_END_IN;
    assign PIN_REQ_OUT = SER0_CLK_OUT;
    assign PIN_REQ_OE  = ~mux & SER0_CLK_OE;
    assign PIN_END_OUT = mux ? tend_n : SER1_CLK_OUT;
    assign PIN_END_OE  = mux | SER1_CLK_OE;

    // serial flags as request when pins serve the serial clocks
    assign req_active = mux ? ~req_n_q : SER_DMA_REQ;
    // i/o to i/o and fixed destination with fixed memory or i/o source refused
    assign mode_ok    = !((dm == dcc_pkg::STEP_FIX && sm[1]) ||
                          (dm == dcc_pkg::STEP_IO && sm == dcc_pkg::STEP_IO));
    // edge mode grants one byte per recognised edge
    assign req_ok     = edge_mode ? (pend && fifo_level == '0) : req_active;
    assign can_read   = run0 && mode_ok && req_ok && fifo_in_ready &&
                        (ch0_cnt - 16'(fifo_level)) != 16'h0000;
    assign start_wr   = st == ST_IDLE && run0 && fifo_out_valid && !can_read;
    assign rd_done    = st == ST_RD && MEM_READY && fifo_in_ready;
    assign wr_done    = st == ST_WR && MEM_READY;
    // channel 0 terminates at count zero
    assign ch0_term   = (wr_done && ch0_cnt == 16'h0001) ||
                        (run0 && st == ST_IDLE && ch0_cnt == 16'h0000);
    // channel 1 terminates at count zero
    assign ch1_term   = CH1_ACTIVE && (ch1_cnt == 16'h0000 || (CH1_ACK && ch1_cnt == 16'h0001));

    dcc_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .rst_n     (RESETN),
        .in_valid  (st == ST_RD && MEM_READY),
        .in_ready  (fifo_in_ready),
        .in_data   (MEM_RDATA),
        .out_valid (fifo_out_valid),
        .out_ready (start_wr),
        .out_data  (fifo_data),
        .level     (fifo_level)
    );

    // request pin filter: change accepted when second and third stages agree
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s1      <= 1'b1;
            s2      <= 1'b1;
            s3      <= 1'b1;
            req_n_q <= 1'b1;
        end
        else
        begin
            s1 <= PIN_REQ_IN;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                req_n_q <= s3;
        end
    end

    // edge capture, set wins over consume
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            req_prev <= 1'b0;
            pend     <= 1'b0;
        end
        else
        begin
            req_prev <= req_active;
            if (wr_done || !edge_mode)
                pend <= 1'b0;
            if (edge_mode && req_active && !req_prev)
                pend <= 1'b1;
        end
    end

    // status and enables
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ch1_en  <= dcc_pkg::RST_BIT;
            ch0_en  <= dcc_pkg::RST_BIT;
            ch1_ie  <= dcc_pkg::RST_BIT;
            ch0_ie  <= dcc_pkg::RST_BIT;
            main_en <= dcc_pkg::RST_BIT;
        end
        else
        begin
            if (wr_stat)
            begin
                ch1_ie <= IO_WDATA[dcc_pkg::STAT_CH1_IE];
                ch0_ie <= IO_WDATA[dcc_pkg::STAT_CH0_IE];
                if (!IO_WDATA[dcc_pkg::STAT_CH1_WM])
                    ch1_en <= IO_WDATA[dcc_pkg::STAT_CH1_EN];
                if (!IO_WDATA[dcc_pkg::STAT_CH0_WM])
                    ch0_en <= IO_WDATA[dcc_pkg::STAT_CH0_EN];
                if ((!IO_WDATA[dcc_pkg::STAT_CH1_WM] && IO_WDATA[dcc_pkg::STAT_CH1_EN]) ||
                    (!IO_WDATA[dcc_pkg::STAT_CH0_WM] && IO_WDATA[dcc_pkg::STAT_CH0_EN]))
                    main_en <= 1'b1;
            end
            // hardware clear wins over a same-cycle write
            if (ch1_term)
                ch1_en <= 1'b0;
            if (ch0_term)
                ch0_en <= 1'b0;
        end
    end

    // mode register
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            mode <= dcc_pkg::RST_MODE;
        else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_MODE)
            mode <= IO_WDATA;
    end

    // source address: byte access, stepping
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            sar <= dcc_pkg::RST_ADDR;
        else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_SAR_LO)
            sar[7:0] <= IO_WDATA;
        else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_SAR_MID)
            sar[15:8] <= IO_WDATA;
        else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_SAR_HI)
            sar[19:16] <= IO_WDATA[3:0];
        else if (rd_done)
            sar <= dcc_pkg::dcc_step(sar, sm);
    end

    // destination address: stepping
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            dar <= dcc_pkg::RST_ADDR;
        else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_DAR_LO)
            dar[7:0] <= IO_WDATA;
        else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_DAR_MID)
            dar[15:8] <= IO_WDATA;
        else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_DAR_HI)
            dar[19:16] <= IO_WDATA[3:0];
        else if (wr_done)
            dar <= dcc_pkg::dcc_step(dar, dm);
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ch0_cnt <= dcc_pkg::RST_CNT;
            ch1_cnt <= dcc_pkg::RST_CNT;
        end
        else
        begin
            if (IO_WR && IO_ADDR == dcc_pkg::ADDR_CNT0_LO)
                ch0_cnt[7:0] <= IO_WDATA;
            else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_CNT0_HI)
                ch0_cnt[15:8] <= IO_WDATA;
            else if (wr_done)
                ch0_cnt <= ch0_cnt - 16'h0001;
            if (IO_WR && IO_ADDR == dcc_pkg::ADDR_CNT1_LO)
                ch1_cnt[7:0] <= IO_WDATA;
            else if (IO_WR && IO_ADDR == dcc_pkg::ADDR_CNT1_HI)
                ch1_cnt[15:8] <= IO_WDATA;
            else if (CH1_ACK && CH1_ACTIVE && ch1_cnt != 16'h0000)
                ch1_cnt <= ch1_cnt - 16'h0001;
        end
    end

    // channel 0 bus engine
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            st        <= ST_IDLE;
            MEM_ADDR  <= dcc_pkg::RST_ADDR;
            MEM_IO    <= 1'b0;
            MEM_RD    <= 1'b0;
            MEM_WR    <= 1'b0;
            MEM_WDATA <= 8'h00;
            tend_n    <= 1'b1;
        end
        else
        begin
            case (st)
                ST_IDLE:
                begin
                    if (can_read)
                    begin
                        st       <= ST_RD;
                        MEM_ADDR <= sar;
                        MEM_IO   <= sm == dcc_pkg::STEP_IO;
                        MEM_RD   <= 1'b1;
                    end
                    else if (start_wr)
                    begin
                        st        <= ST_WR;
                        MEM_ADDR  <= dar;
                        MEM_IO    <= dm == dcc_pkg::STEP_IO;
                        MEM_WR    <= 1'b1;
                        MEM_WDATA <= fifo_data;
                        tend_n    <= ch0_cnt != 16'h0001;
                    end
                end
                ST_RD:
                begin
                    if (rd_done)
                    begin
                        st     <= ST_IDLE;
                        MEM_RD <= 1'b0;
                    end
                end
                ST_WR:
                begin
                    if (wr_done)
                    begin
                        st     <= ST_IDLE;
                        MEM_WR <= 1'b0;
                        tend_n <= 1'b1;
                    end
                end
                default:
                    st <= ST_IDLE;
            endcase
        end
    end

    // register read, status shows running or done
    always_comb
    begin
        case (IO_ADDR)
            dcc_pkg::ADDR_SAR_LO:  rd_mux = sar[7:0];
            dcc_pkg::ADDR_SAR_MID: rd_mux = sar[15:8];
            dcc_pkg::ADDR_SAR_HI:  rd_mux = {4'h0, sar[19:16]};
            dcc_pkg::ADDR_DAR_LO:  rd_mux = dar[7:0];
            dcc_pkg::ADDR_DAR_MID: rd_mux = dar[15:8];
            dcc_pkg::ADDR_DAR_HI:  rd_mux = {4'h0, dar[19:16]};
            dcc_pkg::ADDR_CNT0_LO: rd_mux = ch0_cnt[7:0];
            dcc_pkg::ADDR_CNT0_HI: rd_mux = ch0_cnt[15:8];
            dcc_pkg::ADDR_CNT1_LO: rd_mux = ch1_cnt[7:0];
            dcc_pkg::ADDR_CNT1_HI: rd_mux = ch1_cnt[15:8];
            dcc_pkg::ADDR_STAT:    rd_mux = {ch1_en, ch0_en, dcc_pkg::RST_WMASK, dcc_pkg::RST_WMASK,
                                             ch1_ie, ch0_ie, 1'b0, main_en};
            dcc_pkg::ADDR_MODE:    rd_mux = mode;
            default:               rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
            IO_RDATA <= 8'h00;
        else if (IO_RD)
            IO_RDATA <= rd_mux;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    irq_level_a: assert property (!ch1_en && ch1_ie |-> DMA_IRQ)
        else $error("irq not held while channel 1 off");
    ch1_mask_a: assert property (wr_stat && IO_WDATA[5] && !ch1_term |=> ch1_en == $past(ch1_en))
        else $error("masked write changed channel 1 enable");
    main_set_a: assert property (wr_stat && IO_WDATA[7] && !IO_WDATA[5] |=> main_en)
        else $error("main enable not set by enable write");
    ch1_stop_a: assert property (CH1_ACTIVE && CH1_ACK && ch1_cnt == 16'h0001 |=> !ch1_en && ch1_cnt == 16'h0000)
        else $error("channel 1 not stopped at count zero");
    ch1_gate_a: assert property (!ch1_en |-> !CH1_ACTIVE)
        else $error("channel 1 active while disabled");
    tend_last_a: assert property ($rose(MEM_WR) && $past(ch0_cnt) == 16'h0001 |-> !tend_n ##1 (tend_n || MEM_WR))
        else $error("transfer end not low on last write");
    sar_step_a: assert property (rd_done && sm == 2'b00 && !IO_WR |=> sar == $past(sar) + 20'h00001)
        else $error("source address did not increment");
    dar_step_a: assert property (wr_done && dm == 2'b01 && !IO_WR |=> dar == $past(dar) - 20'h00001)
        else $error("destination address did not decrement");
    bcr_dec_a: assert property (wr_done && !IO_WR |=> ch0_cnt == $past(ch0_cnt) - 16'h0001)
        else $error("byte count did not decrement");
    reserved_mode_a: assert property (!mode_ok && st == ST_IDLE && !fifo_out_valid |=> !MEM_RD && !MEM_WR)
        else $error("reserved mode started a transfer");

    last_byte_c: cover property (wr_done && ch0_cnt == 16'h0001);
    fifo_full_c: cover property (!fifo_in_ready ##1 start_wr);
    edge_start_c: cover property (edge_mode && pend && can_read);
endmodule

// File: shared/dcc_pkg.sv
// Purpose: constants shared by the dma channel control block
// Assumes: 8-bit processor i/o register port, 20-bit physical address
// Notes:   offsets are low i/o address bytes
package dcc_pkg;

    localparam int ADDR_W = 20;
    localparam int CNT_W  = 16;

    // register offsets
    localparam logic [7:0] ADDR_SAR_LO  = 8'h20;
    localparam logic [7:0] ADDR_SAR_MID = 8'h21;
    localparam logic [7:0] ADDR_SAR_HI  = 8'h22;
    localparam logic [7:0] ADDR_DAR_LO  = 8'h23;
    localparam logic [7:0] ADDR_DAR_MID = 8'h24;
    localparam logic [7:0] ADDR_DAR_HI  = 8'h25;
    localparam logic [7:0] ADDR_CNT0_LO = 8'h26;
    localparam logic [7:0] ADDR_CNT0_HI = 8'h27;
    localparam logic [7:0] ADDR_CNT1_LO = 8'h2e;
    localparam logic [7:0] ADDR_CNT1_HI = 8'h2f;
    localparam logic [7:0] ADDR_STAT    = 8'h30;
    localparam logic [7:0] ADDR_MODE    = 8'h31;

    // status/control bit positions
    localparam int STAT_CH1_EN  = 7;
    localparam int STAT_CH0_EN  = 6;
    localparam int STAT_CH1_WM  = 5;
    localparam int STAT_CH0_WM  = 4;
    localparam int STAT_CH1_IE  = 3;
    localparam int STAT_CH0_IE  = 2;
    localparam int STAT_MAIN_EN = 0;

    // mode register field positions
    localparam int MODE_DM   = 4;
    localparam int MODE_SM   = 2;
    localparam int MODE_EDGE = 1;
    localparam int MODE_MUX  = 0;

    // reset values
    localparam logic              RST_BIT  = 1'b0;
    localparam logic              RST_WMASK = 1'b1;
    localparam logic [7:0]        RST_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] RST_ADDR = 20'h00000;
    localparam logic [CNT_W-1:0]  RST_CNT  = 16'h0000;

    // address step modes
    localparam logic [1:0] STEP_INC = 2'b00;
    localparam logic [1:0] STEP_DEC = 2'b01;
    localparam logic [1:0] STEP_FIX = 2'b10;
    localparam logic [1:0] STEP_IO  = 2'b11;

    function automatic logic [ADDR_W-1:0] dcc_step(input logic [ADDR_W-1:0] a, input logic [1:0] m);
        case (m)
            STEP_INC: dcc_step = a + 20'h00001;
            STEP_DEC: dcc_step = a - 20'h00001;
            default:  dcc_step = a;
        endcase
    endfunction

endpackage

// File: verif/dcc_mem_model.sv
// Purpose: memory and i/o bus partner for the dma engine
// Assumes: data of a byte is a fold of its address
// Notes:   ready may stall at random while slow is high
`timescale 1ns/10ps
module dcc_mem_model (
    // clock and stall control
    input  wire logic        clk,
    input  wire logic        slow,
    // dma bus
    input  wire logic [19:0] mem_addr,
    input  wire logic        mem_rd,
    output logic             mem_ready,
    output logic [7:0]       mem_rdata
);
    logic [7:0] last = 8'h00;
    initial mem_ready = 1'b1;
    always @(posedge clk)
    begin
        if (mem_rd && mem_ready)
            last <= mem_rdata;
        #1 mem_ready = slow ? 1'($urandom) : 1'b1;
    end
    // released bus shows the inverse of the last byte
    assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ mem_addr[15:8] ^ {4'h0, mem_addr[19:16]}) : ~last;
endmodule

// File: verif/testbench.sv
// Purpose: self-checking bench for the dma channel control block
// Assumes: 10 MHz clock, inputs moved 1 ns after the rising edge
// Notes:   expected reads and writes queue up, a monitor pops them
`timescale 1ns/10ps
module testbench;
    logic        clk, resetn, io_wr, io_rd, rd_d, mem_io, mem_rd, mem_wr, mem_ready, slow;
    logic        pin_req_in, pin_end_in, ser_req, ch1_ack, ch1_active, irq, s0o, s0e, s1o, s1e;
    logic        req_out, req_oe, end_out, end_oe, s0i, s1i;
    logic [7:0]  io_addr, io_wdata, io_rdata, mem_wdata, mem_rdata;
    logic [19:0] mem_addr;
    logic [7:0]  exp_rd[$];
    logic [29:0] exp_wr[$];
    logic [20:0] exp_ra[$];
    int          err_total = 0;
    int          n_compared = 0;

    dcc_dma_channel_control dut (.CLK(clk), .RESETN(resetn), .IO_ADDR(io_addr), .IO_WR(io_wr),
        .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .MEM_ADDR(mem_addr), .MEM_IO(mem_io),
        .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
        .MEM_READY(mem_ready), .PIN_REQ_IN(pin_req_in), .PIN_REQ_OUT(req_out), .PIN_REQ_OE(req_oe),
        .PIN_END_IN(pin_end_in), .PIN_END_OUT(end_out), .PIN_END_OE(end_oe), .SER0_CLK_IN(s0i),
        .SER0_CLK_OUT(s0o), .SER0_CLK_OE(s0e), .SER1_CLK_IN(s1i), .SER1_CLK_OUT(s1o),
        .SER1_CLK_OE(s1e), .SER_DMA_REQ(ser_req), .CH1_ACK(ch1_ack), .CH1_ACTIVE(ch1_active),
        .DMA_IRQ(irq));
    dcc_mem_model bus (.clk(clk), .slow(slow), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata));

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cyc;
        @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        cyc();
        io_wr = 1'b0;
        cyc();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        io_addr = a;
        io_rd = 1'b1;
        exp_rd.push_back(e);
        cyc();
        io_rd = 1'b0;
        cyc();
    endtask

    task automatic ack;
        ch1_ack = 1'b1;
        cyc();
        ch1_ack = 1'b0;
        cyc();
    endtask

    function automatic logic [23:0] stp(input logic [23:0] a, input logic [1:0] m);
        return (m == 2'b00) ? a + 24'h1 : (m == 2'b01) ? a - 24'h1 : a;
    endfunction

    task automatic xfer(input logic [1:0] sm, input logic [1:0] dm, input int n);
        logic [23:0] s;
        logic [23:0] d;
        logic        rsv;
        logic        mx;
        s = 24'h01fffe;
        d = 24'h030001;
        rsv = (dm == 2'b10) && sm[1];
        mx = dm != 2'b01;
        wr(8'h31, {2'b00, dm, sm, sm[0], mx});
        for (int i = 0; i < 3; i++)
        begin
            wr(8'(8'h20 + i), s[8*i+:8]);
            wr(8'(8'h23 + i), d[8*i+:8]);
        end
        wr(8'h26, n[7:0]);
        wr(8'h27, n[15:8]);
        for (int i = 0; i < n; i++)
        begin
            if (!rsv)
            begin
                exp_ra.push_back({sm == 2'b11, s[19:0]});
                exp_wr.push_back({1'b0, mx && i != n - 1, d[19:0], s[7:0] ^ s[15:8] ^ {4'h0, s[19:16]}});
            end
            s = stp(s, sm);
            d = stp(d, dm);
        end
        pin_req_in = 1'b0;
        ser_req = 1'b1;
        wr(8'h30, 8'h60);
        if (rsv)
        begin
            repeat (30) cyc();
            chk("reserved writes", 0, exp_wr.size());
            rd(8'h30, 8'h71);
            wr(8'h30, 8'h20);
        end
        else
        begin
            for (int k = 0; k < 600 && exp_wr.size() > 0; k++)
            begin
                pin_req_in = 1'(k >> 3);
                ser_req = ~pin_req_in;
                cyc();
            end
            if (exp_wr.size() > 0)
            begin
                chk("pending writes", 0, exp_wr.size());
                conclude();
            end
            rd(8'h30, 8'h31);
            rd(8'h26, 8'h00);
        end
        pin_req_in = 1'b1;
        ser_req = 1'b0;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (rd_d)
            chk("read data", exp_rd.size() ? exp_rd.pop_front() : 'x, io_rdata);
        rd_d <= io_rd;
        if (mem_rd && mem_ready)
            chk("read cycle", exp_ra.size() ? exp_ra.pop_front() : 'x, {mem_io, mem_addr});
        if (mem_wr && mem_ready)
            chk("write cycle", exp_wr.size() ? exp_wr.pop_front() : 'x, {mem_io, end_out, mem_addr, mem_wdata});
    end

    initial
    begin
        {resetn, io_wr, io_rd, ser_req, ch1_ack, slow, s0o, s0e, s1o, s1e, pin_end_in} = '0;
        {io_addr, io_wdata} = '0;
        pin_req_in = 1'b1;
        void'($urandom(66724));
        repeat (10) @(posedge clk);
        #1 resetn = 1'b1;
        cyc();
        rd(8'h30, 8'h30);
        for (int i = 0; i < 4; i++)
        begin
            {pin_req_in, pin_end_in, s0o, s0e, s1o, s1e} = 6'($urandom);
            #10;
            chk("pin share", {pin_req_in, pin_end_in, s1o, s1e, s0e, s0o}, {s0i, s1i, end_out, end_oe, req_oe, req_out});
            cyc();
        end
        {pin_req_in, s1o} = 2'b10;
        wr(8'h31, 8'h01);
        chk("pin share", 4'b1100, {end_oe, end_out, s0i, s1i});
        wr(8'h20, 8'ha5);
        wr(8'h21, 8'h5a);
        wr(8'h22, 8'hff);
        rd(8'h20, 8'ha5);
        rd(8'h21, 8'h5a);
        rd(8'h22, 8'h0f);
        rd(8'h3f, 8'h00);
        wr(8'h2e, 8'h02);
        wr(8'h2f, 8'h00);
        wr(8'h30, 8'h98);
        chk("ch1 run", 2'b10, {ch1_active, irq});
        ack();
        wr(8'h30, 8'h18);
        chk("ch1 halt", 2'b01, {ch1_active, irq});
        wr(8'h30, 8'hb8);
        chk("ch1 masked", 2'b01, {ch1_active, irq});
        wr(8'h30, 8'h98);
        chk("ch1 resume", 2'b10, {ch1_active, irq});
        ack();
        chk("ch1 done", 2'b01, {ch1_active, irq});
        rd(8'h30, 8'h39);
        wr(8'h30, 8'h30);
        for (int dm = 0; dm < 3; dm++)
            for (int sm = 0; sm < 4; sm++)
            begin
                slow = 1'(sm);
                xfer(2'(sm), 2'(dm), 1 + $urandom % 10);
            end
        repeat (3) cyc();
        conclude();
    end
endmodule
